// [test/scc_front_model.sv]
`timescale 1ns/1ps
// ---------------------------------------------------------------
// sensing front end: fixed readings, heat sink can run hot
// ---------------------------------------------------------------
module scc_front_model #(
	parameter logic [15:0] RAW = 16'h0123
) (
	input wire logic hot, // heat sink overheats
	output logic [15:0] raw_temp, // unfiltered value
	output logic [15:0] int_temp, // reference temperature, C
	output logic [15:0] hs_temp, // heat sink temperature, C
	output logic [15:0] hs_limit // shutdown limit, C
);
	// levels only; no control loops here, so recal never upsets them
	assign raw_temp = RAW;
	assign int_temp = 16'h0019;
	assign hs_temp = hot ? 16'h005F : 16'h003E;
	assign hs_limit = 16'h0050;
endmodule : scc_front_model

// [test/scc_sysconf_asserts.sv]
`timescale 1ns/1ps
// ---------------------------------------------------------------
// port checks for the system config block
// ---------------------------------------------------------------
module scc_sysconf_chk import scc_pkg::*; #(
	parameter longint RECAL_CYCLES = 20
) (
	input wire logic mclk, // clock
	input wire logic rst_n, // async reset
	input wire logic [ADDR_W-1:0] addr, // register address
	input wire logic [31:0] wdata, // write data
	input wire logic wr, // write strobe
	input wire logic [15:0] raw_temp, // unfiltered value
	input wire logic [15:0] hs_temp, // heat sink temperature
	input wire logic [15:0] hs_limit, // heat sink limit
	input wire logic [15:0] refill_value, // seeded value
	input wire logic filter_refill_cmd, // refill pulse
	input wire logic self_recalibrate_cmd, // recal level
	input wire logic heater_shutdown, // shutdown level
	input wire logic home_cmd, // home pulse
	input wire logic bus_port_en, // bus port on
	input wire logic serial_port_en, // serial port on
	input wire logic port_init, // port initialising
	input wire logic [4:0] bus_address, // bus address
	input wire logic [7:0] sync_filter_tap_count, // taps
	input wire logic mains_frequency_setting, // 1 = 60 Hz
	input wire logic [1:0] display_digit_setting, // digits
	input wire logic powerup_regulate_setting // power up in control
);
	logic [31:0] recal_cnt_q; // cycles the recal level has stood

	// count the recal level so its length can be judged when it drops
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) recal_cnt_q <= '0;
		else recal_cnt_q <= self_recalibrate_cmd ? recal_cnt_q + 32'h1 : '0;
	end

	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);

	reset_values_a:
	assert property ($rose(rst_n) |-> bus_address == ADDR_RST && sync_filter_tap_count == TAPS_RST
		&& !powerup_regulate_setting) else $error("wrong setting out of reset");
	addr_take_a:
	assert property (wr && addr == OFS_ADDR && wdata >= 1 && wdata <= 31
		|=> bus_address == $past(wdata)) else $error("bus address not taken");
	addr_keep_a:
	assert property (wr && addr == OFS_ADDR && (wdata == 0 || wdata > 31)
		|=> $stable(bus_address)) else $error("bad bus address taken");
	port_seq_a:
	assert property (wr && addr == OFS_PORT && wdata <= 1 |=> !bus_port_en && !serial_port_en
		##1 port_init [*4] ##1 !port_init && bus_port_en != serial_port_en)
		else $error("port restart order wrong");
	port_pick_a:
	assert property (wr && addr == OFS_PORT && wdata == 1 |-> ##6 serial_port_en && !bus_port_en)
		else $error("serial port not chosen");
	mains_a:
	assert property (wr && addr == OFS_MAINS && (wdata == 32'h32 || wdata == 32'h3C)
		|=> mains_frequency_setting == $past(wdata[3])) else $error("mains setting wrong");
	digit_keep_a:
	assert property (wr && addr == OFS_DIGITS && wdata > 3 |=> $stable(display_digit_setting))
		else $error("bad digit count taken");
	refill_pulse_a:
	assert property (wr && addr == OFS_ACTION && wdata[BIT_REFILL] |=> filter_refill_cmd
		&& refill_value == $past(raw_temp) ##1 !filter_refill_cmd) else $error("refill wrong");
	home_pulse_a:
	assert property (wr && addr == OFS_ACTION && wdata[BIT_HOME] |=> home_cmd ##1 !home_cmd)
		else $error("home pulse wrong");
	recal_len_a:
	assert property ($fell(self_recalibrate_cmd) |-> recal_cnt_q == RECAL_CYCLES)
		else $error("recal length wrong");
	shutdown_a:
	assert property ($signed(hs_temp) > $signed(hs_limit) |-> ##[0:2] heater_shutdown)
		else $error("no shutdown on hot heat sink");
endmodule : scc_sysconf_chk

bind scc_sysconf scc_sysconf_chk #(.RECAL_CYCLES(RECAL_CYCLES)) i_scc_sysconf_chk (.mclk, .rst_n,
	.addr, .wdata, .wr, .raw_temp, .hs_temp, .hs_limit, .refill_value, .filter_refill_cmd,
	.self_recalibrate_cmd, .heater_shutdown, .home_cmd, .bus_port_en, .serial_port_en,
	.port_init, .bus_address, .sync_filter_tap_count, .mains_frequency_setting,
	.display_digit_setting, .powerup_regulate_setting);

// [test/tb.sv]
`timescale 1ns/1ps
// ---------------------------------------------------------------
// register level bench for the system config block
// ---------------------------------------------------------------
module tb;
	import scc_pkg::*;
	localparam int RC = 20; // shortened recal span
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] addr = '0;
	logic [31:0] wdata = '0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic hot = 1'b0;
	logic [31:0] rdata, setup_q;
	logic [15:0] raw_temp, int_temp, hs_temp, hs_limit, refill_value;
	logic filter_refill_cmd, self_recalibrate_cmd, heater_shutdown, home_cmd, bus_port_en;
	logic serial_port_en, port_init, mains_frequency_setting, powerup_regulate_setting, setup_load;
	logic [4:0] bus_address;
	logic [7:0] sync_filter_tap_count;
	logic [1:0] display_digit_setting;
	logic [31:0] av [5] = '{32'd14, 32'd0, 32'd32, 32'd31, 32'd1};
	logic [31:0] ae [5] = '{32'd14, 32'd14, 32'd14, 32'd31, 32'd1};
	int miscompares = 0;
	int tests_run = 0;

	// level values are arbitrary
	scc_sysconf #(.RECAL_CYCLES(RC), .HW_LEVEL(8'h5A), .FW_LEVEL(16'h0318)) i_scc_sysconf (
		.mclk, .rst_n, .addr, .wdata, .wr, .rd, .rdata, .raw_temp, .int_temp, .hs_temp,
		.hs_limit, .refill_value, .filter_refill_cmd, .self_recalibrate_cmd, .heater_shutdown,
		.home_cmd, .bus_port_en, .serial_port_en, .port_init, .bus_address,
		.sync_filter_tap_count, .mains_frequency_setting, .display_digit_setting,
		.powerup_regulate_setting, .setup_q, .setup_load);
	scc_front_model i_scc_front_model (.hot, .raw_temp, .int_temp, .hs_temp, .hs_limit);

	always #10 mclk = ~mclk;

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : check

	// one-cycle write; returns once its effect has landed
	task automatic wreg(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge mclk);
		wr <= 1'b0;
		#1;
	endtask : wreg

	// one-cycle read; data only valid in the following cycle
	task automatic rreg(input logic [7:0] a, input logic [31:0] exp);
		@(posedge mclk);
		addr <= a;
		rd <= 1'b1;
		@(posedge mclk);
		rd <= 1'b0;
		#1 check(rdata, exp);
	endtask : rreg

	task automatic tally_and_finish();
		if (miscompares == 0 && tests_run > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : tally_and_finish

	// hang guard, far beyond the few hundred cycles the run needs
	initial begin
		repeat (6000) @(posedge mclk);
		miscompares++;
		tally_and_finish();
	end

	// main sequence
	initial begin
		repeat (4) @(posedge mclk);
		rst_n <= 1'b1;
		repeat (10) @(posedge mclk);
		rreg(OFS_ADDR, 32'h0C);
		rreg(OFS_TAPS, 32'h07);
		rreg(OFS_PUREG, 32'h0);
		rreg(OFS_DIGITS, 32'h0);
		rreg(OFS_PORT, 32'h0);
		rreg(OFS_UNAME, 32'h20);
		rreg(OFS_HWLVL, 32'h5A);
		rreg(OFS_FWLVL, 32'h0318);
		rreg(OFS_ITEMP, 32'h19);
		rreg(OFS_HSTEMP, 32'h3E);
		check(32'(mains_frequency_setting), 32'h0);
		// address ends taken, zero and 32 refused
		for (int i = 0; i < 5; i++) begin
			wreg(OFS_ADDR, av[i]);
			repeat (6) @(posedge mclk);
			rreg(OFS_ADDR, ae[i]);
		end
		// port select, then the same port again acts as a restart
		wreg(OFS_PORT, 32'h1);
		repeat (6) @(posedge mclk);
		rreg(OFS_PORT, 32'h1);
		wreg(OFS_PORT, 32'h1);
		check(32'(serial_port_en), 32'h0);
		@(posedge mclk);
		#1 check(32'(port_init), 32'h1);
		repeat (6) @(posedge mclk);
		check(32'(serial_port_en), 32'h1);
		wreg(OFS_PORT, 32'h2);
		repeat (6) @(posedge mclk);
		rreg(OFS_PORT, 32'h1);
		wreg(OFS_PORT, 32'h0);
		repeat (6) @(posedge mclk);
		check(32'(bus_port_en), 32'h1);
		// mains, digits, taps, power-up setting
		wreg(OFS_MAINS, 32'h3C);
		rreg(OFS_MAINS, 32'h3C);
		wreg(OFS_MAINS, 32'h37);
		check(32'(mains_frequency_setting), 32'h1);
		wreg(OFS_MAINS, 32'h32);
		check(32'(mains_frequency_setting), 32'h0);
		for (int i = 0; i < 4; i++) begin
			wreg(OFS_DIGITS, 32'(i));
			check(32'(display_digit_setting), 32'(i));
		end
		wreg(OFS_DIGITS, 32'h4);
		check(32'(display_digit_setting), 32'h3);
		rreg(OFS_ITEMP, 32'h19);
		wreg(OFS_TAPS, 32'h0);
		wreg(OFS_TAPS, 32'h9);
		rreg(OFS_TAPS, 32'h9);
		wreg(OFS_PUREG, 32'h1);
		rreg(OFS_PUREG, 32'h1);
		// names: last unit char, high byte refused, a slot name
		wreg(OFS_UNAME + 8'h0E, 32'h5A);
		rreg(OFS_UNAME + 8'h0E, 32'h5A);
		wreg(OFS_UNAME, 32'h80);
		rreg(OFS_UNAME, 32'h20);
		wreg(8'h50, 32'h41);
		rreg(8'h50, 32'h41);
		wreg(8'h0E, 32'h5);
		rreg(OFS_ADDR, 32'h1);
		// actions: refill with home, then recal while loops are idle
		wreg(OFS_ACTION, 32'h5);
		check(32'(refill_value), 32'h0123);
		check(32'(home_cmd), 32'h1);
		wreg(OFS_ACTION, 32'h2);
		check(32'(self_recalibrate_cmd), 32'h1);
		repeat (RC) @(posedge mclk);
		#1 check(32'(self_recalibrate_cmd), 32'h0);
		@(posedge mclk);
		hot <= 1'b1;
		repeat (3) @(posedge mclk);
		hot <= 1'b0;
		repeat (3) @(posedge mclk);
		check(32'(heater_shutdown), 32'h1);
		// save a distinct word in every slot, restore in reverse
		for (int i = 0; i < 6; i++) begin
			wreg(OFS_SETUP, 32'hC0DE0000 + 32'(i));
			wreg(OFS_SLOT, 32'(i));
			wreg(OFS_ACTION, 32'h8);
		end
		for (int i = 5; i >= 0; i--) begin
			wreg(OFS_SLOT, 32'(i));
			wreg(OFS_ACTION, 32'h10);
			check(32'(setup_load), 32'h1);
			// the stored word comes out of the slot store one cycle after the strobe
			@(posedge mclk);
			#1 check(setup_q, 32'hC0DE0000 + 32'(i));
			check(32'(setup_load), 32'h0);
		end
		wreg(OFS_SLOT, 32'h6);
		rreg(OFS_SLOT, 32'h0);
		// bus port idle and enabled, recal done, shutdown latched
		rreg(OFS_STATUS, 32'h11);
		tally_and_finish();
	end
endmodule : tb

// [verilog/scc_pkg.sv]
package scc_pkg;

	// ---------------------------------------------------------------
	// register offsets (word addresses on the plain port)
	// ---------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam logic [7:0] OFS_PORT = 8'h00;
	localparam logic [7:0] OFS_ADDR = 8'h01;
	localparam logic [7:0] OFS_TAPS = 8'h02;
	localparam logic [7:0] OFS_MAINS = 8'h03;
	localparam logic [7:0] OFS_DIGITS = 8'h04;
	localparam logic [7:0] OFS_PUREG = 8'h05;
	localparam logic [7:0] OFS_ACTION = 8'h06;
	localparam logic [7:0] OFS_STATUS = 8'h07;
	localparam logic [7:0] OFS_ITEMP = 8'h08;
	localparam logic [7:0] OFS_HSTEMP = 8'h09;
	localparam logic [7:0] OFS_HWLVL = 8'h0A;
	localparam logic [7:0] OFS_FWLVL = 8'h0B;
	localparam logic [7:0] OFS_SLOT = 8'h0C;
	localparam logic [7:0] OFS_SETUP = 8'h0D;
	localparam logic [7:0] OFS_UNAME = 8'h10;
	localparam logic [7:0] OFS_SNAME = 8'h20;
	localparam logic [7:0] OFS_SDATA = 8'h40;

	// ---------------------------------------------------------------
	// field layouts and values
	// ---------------------------------------------------------------
	localparam int NAME_LEN = 15;
	localparam int SLOTS = 6;
	localparam int NAMED_SLOTS = 4;
	localparam int SETUP_W = 32;
	localparam logic [4:0] ADDR_MIN = 5'h01;
	localparam logic [4:0] ADDR_MAX = 5'h1F;
	localparam logic [4:0] ADDR_RST = 5'h0C;
	localparam logic [7:0] TAPS_RST = 8'h07;
	localparam logic [7:0] MAINS_50 = 8'h32;
	localparam logic [7:0] MAINS_60 = 8'h3C;
	localparam logic [1:0] DIG_FULL = 2'h0;
	localparam logic [2:0] BIT_REFILL = 3'd0;
	localparam logic [2:0] BIT_RECAL = 3'd1;
	localparam logic [2:0] BIT_HOME = 3'd2;
	localparam logic [2:0] BIT_SAVE = 3'd3;
	localparam logic [2:0] BIT_RESTORE = 3'd4;

	// ---------------------------------------------------------------
	// timing
	// ---------------------------------------------------------------
	localparam longint CLK_HZ = 50000000;
	localparam longint RECAL_MS = 500;
	localparam longint RECAL_CYC = CLK_HZ / 1000 * RECAL_MS;
	localparam longint PORT_INIT_CYC = 4;

	typedef enum logic [1:0] {
		SCC_PORT_BUS = 2'h0,
		SCC_PORT_SERIAL = 2'h1
	} scc_port_e;

	typedef enum logic [1:0] {
		SCC_IDLE = 2'b00,
		SCC_DISABLE = 2'b01,
		SCC_INIT = 2'b11
	} scc_pst_e;

	typedef struct packed {
		logic [7:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} scc_req_s;

endpackage : scc_pkg

// [verilog/scc_slot_mem.sv]
`timescale 1ns/1ps
// setup slot store, one word per slot, registered read
module scc_slot_mem import scc_pkg::*; #(
	parameter int DEPTH = SLOTS,
	parameter int WIDTH = SETUP_W
) (
	input wire logic mclk, // clock
	input wire logic we, // write enable
	input wire logic [2:0] waddr, // write slot
	input wire logic [WIDTH-1:0] wdata, // write word
	input wire logic [2:0] raddr, // read slot
	output logic [WIDTH-1:0] rdata // registered read word
);
	logic [WIDTH-1:0] mem [DEPTH];

	// slot addresses are three bits wide, so deeper stores cannot be reached
	if (DEPTH > 8 || DEPTH < 1) begin : g_depth_chk
		$error("scc_slot_mem: depth outside 1 to 8");
	end

	// write port
	always_ff @(posedge mclk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end

	// read port
	always_ff @(posedge mclk) begin
		rdata <= mem[raddr];
	end
endmodule : scc_slot_mem

// [verilog/scc_sysconf.sv]
// Design decisions made here: the plain strobed port and the address map.
`timescale 1ns/1ps
// Summary of operation
// - bus address accepted only from 1 to 31
// - bus address resets to twelve
// - address write re-initialises the chosen port
// - port select is bus or serial, readable
// - port write disables all, then inits chosen
// - refill loads raw value into filter history
// - internal temperature readable in Celsius
// - recalibrate both inputs, about half second
// - heat sink temperature monitored, readable
// - sync filter taps settable, default seven
// - unit name holds fifteen characters
// - mains frequency only 50 or 60
// - display digits full, one, two, three
// - display digits affect front panel only
// - power-up regulate on or off, default off
// - six setup slots hold one 32-bit setup word each
// - save copies setup into slot 0-5
// - restore loads setup from slot 0-5
// - slot names fifteen characters, slots 0-3
// - hardware and firmware levels readable
// - home shows operate screen
// - short keywords truncated to four or three; not done here, left to the host parser
module scc_sysconf import scc_pkg::*; #(
	parameter longint RECAL_CYCLES = RECAL_CYC,
	parameter logic [7:0] HW_LEVEL = 8'h01, // arbitrary value
	parameter logic [15:0] FW_LEVEL = 16'h0001 // arbitrary value
) (
	input wire logic mclk, // 50 MHz clock
	input wire logic rst_n, // async reset, active low
	input wire logic [ADDR_W-1:0] addr, // register address
	input wire logic [31:0] wdata, // write data
	input wire logic wr, // write strobe
	input wire logic rd, // read strobe
	output logic [31:0] rdata, // read data, cycle after rd
	input wire logic [15:0] raw_temp, // unfiltered channel value
	input wire logic [15:0] int_temp, // reference temperature, C
	input wire logic [15:0] hs_temp, // heat sink temperature, C
	input wire logic [15:0] hs_limit, // heat sink shutdown limit, C
	output logic [15:0] refill_value, // value seeded into history
	output logic filter_refill_cmd, // seed all history entries
	output logic self_recalibrate_cmd, // recalibration running
	output logic heater_shutdown, // heat sink over limit
	output logic home_cmd, // go to operate screen
	output logic bus_port_en, // bus port enabled
	output logic serial_port_en, // serial port enabled
	output logic port_init, // chosen port initialising
	output logic [4:0] bus_address, // bus address in use
	output logic [7:0] sync_filter_tap_count, // filter taps
	output logic mains_frequency_setting, // 1 = 60 Hz
	output logic [1:0] display_digit_setting, // 0 full, else digits
	output logic powerup_regulate_setting, // power up in control
	output logic [SETUP_W-1:0] setup_q, // live setup word
	output logic setup_load // setup replaced by restore
);
	// ---------------------------------------------------------------
	// reset release
	// ---------------------------------------------------------------
	logic [1:0] rst_sync_q;
	logic rst_ok;

	// two flops so release is clean against mclk
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rst_sync_q <= 2'b00;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_ok = rst_sync_q[1];

	// a zero count would hold the recal level for 2**32 cycles; the counter is 32 bits
	if (RECAL_CYCLES < 1 || (RECAL_CYCLES >> 32) != 0) begin : g_recal_chk
		$error("scc_sysconf: recal count outside 1 to 2**32-1");
	end

	// slot index is three bits; only the first slots carry names
	if (SLOTS > 8 || NAMED_SLOTS > SLOTS) begin : g_slot_chk
		$error("scc_sysconf: slot counts not served");
	end

	// ---------------------------------------------------------------
	// decode
	// ---------------------------------------------------------------
	scc_req_s req;
	logic wr_act;
	logic [7:0] wd8;
	logic [4:0] wd5;
	// one offset per command: keyword spelling and shortening stay with the host parser
	assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};
	assign wr_act = req.wr && (req.addr == OFS_ACTION);
	assign wd8 = req.wdata[7:0];
	assign wd5 = req.wdata[4:0];

	// ---------------------------------------------------------------
	// port selection
	// ---------------------------------------------------------------
	scc_pst_e pst_q;
	scc_port_e port_q;
	logic [2:0] pcnt_q;
	logic port_wr;
	logic addr_ok;
	assign addr_ok = (req.wdata[31:5] == '0) && (wd5 >= ADDR_MIN) && (wd5 <= ADDR_MAX);
	assign port_wr = req.wr && (req.addr == OFS_PORT) && (req.wdata[31:1] == '0);

	// selected port and address
	always_ff @(posedge mclk or negedge rst_ok) begin
		if (!rst_ok) begin
			port_q <= SCC_PORT_BUS;
			bus_address <= ADDR_RST;
		end else begin
			if (port_wr) begin
				port_q <= scc_port_e'({1'b0, req.wdata[0]});
			end
			if (req.wr && req.addr == OFS_ADDR && addr_ok) begin
				bus_address <= wd5;
			end
		end
	end

	// re-init sequence: disable all, then init chosen port
	always_ff @(posedge mclk or negedge rst_ok) begin
		if (!rst_ok) begin
			pst_q <= SCC_DISABLE;
			pcnt_q <= 3'd0;
		end else begin
			// a new write restarts the sequence even if already running
			if (port_wr || (req.wr && req.addr == OFS_ADDR && addr_ok)) begin
				pst_q <= SCC_DISABLE;
				pcnt_q <= 3'd0;
			end else begin
				unique case (pst_q)
					SCC_IDLE: begin
						pcnt_q <= 3'd0;
					end
					SCC_DISABLE: begin
						pst_q <= SCC_INIT;
						pcnt_q <= 3'd0;
					end
					SCC_INIT: begin
						pcnt_q <= pcnt_q + 3'd1;
						if (pcnt_q == 3'(PORT_INIT_CYC - 1)) begin
							pst_q <= SCC_IDLE;
						end
					end
					default: begin
						pst_q <= SCC_IDLE;
					end
				endcase
			end
		end
	end

	assign port_init = (pst_q == SCC_INIT);
	assign bus_port_en = (pst_q != SCC_DISABLE) && (port_q == SCC_PORT_BUS);
	assign serial_port_en = (pst_q != SCC_DISABLE) && (port_q == SCC_PORT_SERIAL);

	// ---------------------------------------------------------------
	// plain settings
	// ---------------------------------------------------------------
	// illegal values leave the setting as it was
	always_ff @(posedge mclk or negedge rst_ok) begin
		if (!rst_ok) begin
			sync_filter_tap_count <= TAPS_RST;
			mains_frequency_setting <= 1'b0;
			display_digit_setting <= DIG_FULL;
			powerup_regulate_setting <= 1'b0;
		end else if (req.wr) begin
			if (req.addr == OFS_TAPS && req.wdata[31:8] == '0 && wd8 != 8'h00) begin
				sync_filter_tap_count <= wd8;
			end
			if (req.addr == OFS_MAINS && req.wdata[31:8] == '0) begin
				if (wd8 == MAINS_50) mains_frequency_setting <= 1'b0;
				if (wd8 == MAINS_60) mains_frequency_setting <= 1'b1;
			end
			if (req.addr == OFS_DIGITS && req.wdata[31:2] == '0) begin
				display_digit_setting <= req.wdata[1:0];
			end
			if (req.addr == OFS_PUREG && req.wdata[31:1] == '0) begin
				powerup_regulate_setting <= req.wdata[0];
			end
		end
	end

	// ---------------------------------------------------------------
	// one-shot actions
	// ---------------------------------------------------------------
	logic [31:0] rcnt_q;

	// refill and home are single-cycle pulses
	always_ff @(posedge mclk or negedge rst_ok) begin
		if (!rst_ok) begin
			filter_refill_cmd <= 1'b0;
			home_cmd <= 1'b0;
			refill_value <= 16'h0000;
		end else begin
			filter_refill_cmd <= wr_act && req.wdata[BIT_REFILL];
			home_cmd <= wr_act && req.wdata[BIT_HOME];
			if (wr_act && req.wdata[BIT_REFILL]) begin
				refill_value <= raw_temp;
			end
		end
	end

	// recalibration holds for about half a second; a repeat request restarts
	always_ff @(posedge mclk or negedge rst_ok) begin
		if (!rst_ok) begin
			self_recalibrate_cmd <= 1'b0;
			rcnt_q <= 32'h0;
		end else if (wr_act && req.wdata[BIT_RECAL]) begin
			self_recalibrate_cmd <= 1'b1;
			rcnt_q <= 32'(RECAL_CYCLES - 1);
		end else if (self_recalibrate_cmd) begin
			if (rcnt_q == 32'h0) begin
				self_recalibrate_cmd <= 1'b0;
			end else begin
				rcnt_q <= rcnt_q - 32'h1;
			end
		end
	end

	// heat sink watch, level that latches until reset
	always_ff @(posedge mclk or negedge rst_ok) begin
		if (!rst_ok) begin
			heater_shutdown <= 1'b0;
		end else if ($signed(hs_temp) > $signed(hs_limit)) begin
			heater_shutdown <= 1'b1;
		end
	end

	// ---------------------------------------------------------------
	// setup slots
	// ---------------------------------------------------------------
	logic [2:0] slot_q;
	logic [SETUP_W-1:0] mem_rd;
	logic save_go;
	logic rest_go;
	logic rest_q;
	assign save_go = wr_act && req.wdata[BIT_SAVE] && (slot_q < 3'(SLOTS));
	assign rest_go = wr_act && req.wdata[BIT_RESTORE] && (slot_q < 3'(SLOTS));

	scc_slot_mem #(.DEPTH(SLOTS), .WIDTH(SETUP_W)) u_mem (
		.mclk(mclk),
		.we(save_go),
		.waddr(slot_q),
		.wdata(setup_q),
		.raddr(slot_q),
		.rdata(mem_rd)
	);

	// slot index and live setup word
	always_ff @(posedge mclk or negedge rst_ok) begin
		if (!rst_ok) begin
			slot_q <= 3'd0;
			setup_q <= '0;
			rest_q <= 1'b0;
		end else begin
			rest_q <= rest_go;
			if (req.wr && req.addr == OFS_SLOT && req.wdata[31:3] == '0
				&& req.wdata[2:0] < 3'(SLOTS)) begin
				slot_q <= req.wdata[2:0];
			end
			if (req.wr && req.addr == OFS_SETUP) begin
				setup_q <= req.wdata;
			end else if (rest_q) begin
				setup_q <= mem_rd;
			end
		end
	end
	assign setup_load = rest_q;

	// ---------------------------------------------------------------
	// name strings: unit name plus four slot names, byte per word
	// ---------------------------------------------------------------
	logic [7:0] uname_q [NAME_LEN];
	logic [7:0] sname_q [NAMED_SLOTS][NAME_LEN];
	// slot names take sixteen words each, the last of every group unused
	localparam logic [7:0] SNAME_END = OFS_SNAME + 8'(NAMED_SLOTS * 16);

	// 7-bit values only (0 to 0x7F); index 15 and above does not exist
	genvar gi, gs;
	generate
		for (gi = 0; gi < NAME_LEN; gi++) begin : g_uname
			always_ff @(posedge mclk or negedge rst_ok) begin
				if (!rst_ok) begin
					uname_q[gi] <= 8'h20;
				end else if (req.wr && req.addr == OFS_UNAME + 8'(gi)
					&& req.wdata[31:7] == '0) begin
					uname_q[gi] <= wd8;
				end
			end
			for (gs = 0; gs < NAMED_SLOTS; gs++) begin : g_sname
				always_ff @(posedge mclk or negedge rst_ok) begin
					if (!rst_ok) begin
						sname_q[gs][gi] <= 8'h20;
					end else if (req.wr && req.addr == OFS_SNAME + 8'(gs * 16 + gi)
						&& req.wdata[31:7] == '0) begin
						sname_q[gs][gi] <= wd8;
					end
				end
			end
		end
	endgenerate

	// ---------------------------------------------------------------
	// read back
	// ---------------------------------------------------------------
	logic [31:0] rd_d;

	// unmapped addresses read as zero
	always_comb begin
		rd_d = 32'h0;
		unique case (req.addr)
			OFS_PORT: rd_d = {30'h0, port_q};
			OFS_ADDR: rd_d = {27'h0, bus_address};
			OFS_TAPS: rd_d = {24'h0, sync_filter_tap_count};
			OFS_MAINS: rd_d = {24'h0, mains_frequency_setting ? MAINS_60 : MAINS_50};
			OFS_DIGITS: rd_d = {30'h0, display_digit_setting};
			OFS_PUREG: rd_d = {31'h0, powerup_regulate_setting};
			OFS_STATUS: rd_d = {27'h0, heater_shutdown, port_init,
				self_recalibrate_cmd, serial_port_en, bus_port_en};
			OFS_ITEMP: rd_d = {{16{int_temp[15]}}, int_temp};
			OFS_HSTEMP: rd_d = {{16{hs_temp[15]}}, hs_temp};
			OFS_HWLVL: rd_d = {24'h0, HW_LEVEL};
			OFS_FWLVL: rd_d = {16'h0, FW_LEVEL};
			OFS_SLOT: rd_d = {29'h0, slot_q};
			OFS_SETUP: rd_d = setup_q;
			default: begin
				if (req.addr >= OFS_UNAME && req.addr < OFS_UNAME + 8'(NAME_LEN)) begin
					rd_d = {24'h0, uname_q[4'(req.addr - OFS_UNAME)]};
				end else if (req.addr >= OFS_SNAME && req.addr < SNAME_END
					&& req.addr[3:0] != 4'hF) begin
					rd_d = {24'h0, sname_q[2'(req.addr[5:4] - 2'h2)][req.addr[3:0]]};
				end
			end
		endcase
	end

	// data stand only in the cycle after the read strobe
	always_ff @(posedge mclk or negedge rst_ok) begin
		if (!rst_ok) begin
			rdata <= 32'h0;
		end else begin
			rdata <= req.rd ? rd_d : 32'h0;
		end
	end
endmodule : scc_sysconf
